// file: common/pcm_slot_switch_pkg.sv
// Constants, field layouts and carrier types for the PCM slot switch and strobe block.
// Assumes a byte-wide processor register port and a highway bit clock of 256 bits a frame.
//
// Contract
// - Highway bit timing lags frame sync by separate tx and rx amounts, same on both highways.
// - The clock phase shift register is write-only and holds zero after reset.
// - The shift byte holds 3-bit tx and rx fields, each 0 to 7; the top two bits are ignored.
// - The actual shift is the code plus two modulo eight.
// - Each slot entry has two mode bits: 11 none, 10 highway 1, 01 highway 0, 00 processor.
// - The strobe configuration register is read/write and zero, strobe inactive, after reset.
// - Strobe config: bits 7..4 position or direction/channel, bit 3 select, bit 2 coverage.
// - Select clear: strobe high in a channel's signaling only if channel and direction are set.
// - Select and coverage set: the strobe covers five bits and is always high at bit 0.
// - Select set, coverage clear: seven tx bits and six rx bits, always high at tx bits 2..0 and rx bits 1..0.
// - In bit-select mode a set position bit drives the strobe high there in rx and low in tx.
// - The strobe is frame-synchronous and steers the six spare signaling bits to expansion logic.
package pcm_slot_switch_pkg;

   // Register selects on the processor port.
   localparam logic [4:0] REG_PSR        = 5'h00;
   localparam logic [4:0] REG_SCR        = 5'h01;
   localparam logic [4:0] REG_STATUS     = 5'h02;
   localparam logic [4:0] REG_ENTRY_BASE = 5'h10;

   // Entry table: eight transmit entries then eight receive entries.
   localparam int         NUM_ENTRIES = 16;
   localparam int         NUM_CHAN    = 8;

   // Reset values.
   localparam logic [7:0] PSR_RESET   = 8'h00;
   localparam logic [7:0] SCR_RESET   = 8'h00;
   localparam logic [7:0] ENTRY_RESET = 8'hC0;

   // Shift code bias and frame timing.
   localparam logic [2:0] SHIFT_BIAS    = 3'h2;
   localparam logic [7:0] SYNC_LATENCY  = 8'h03;
   localparam int         HANDOFF_LIMIT = 20;

   // Subscriber line byte numbers (bits 5..3 of the frame bit count).
   localparam logic [2:0] SUB_TX_SIG_A = 3'h2;
   localparam logic [2:0] SUB_TX_SIG_B = 3'h3;
   localparam logic [2:0] SUB_RX_SIG_A = 3'h6;
   localparam logic [2:0] SUB_RX_SIG_B = 3'h7;

   // Position bit offsets in the signaling byte.
   localparam logic [2:0] POS_OFS_FULL  = 3'h1;
   localparam logic [2:0] POS_OFS_TX    = 3'h3;
   localparam logic [2:0] POS_OFS_RX    = 3'h2;
   localparam logic [2:0] FIX_TX_TOP    = 3'h2;
   localparam logic [2:0] FIX_RX_TOP    = 3'h1;

   typedef enum logic [1:0] {
      MODE_CPU  = 2'b00,
      MODE_HW0  = 2'b01,
      MODE_HW1  = 2'b10,
      MODE_NONE = 2'b11
   } slot_mode_e;

   typedef enum logic {
      HAND_IDLE = 1'b0,
      HAND_BUSY = 1'b1
   } hand_state_e;

   typedef struct packed {
      logic [1:0] spare;
      logic [2:0] txShift;
      logic [2:0] rxShift;
   } psr_s;

   typedef struct packed {
      logic       rxOrD;
      logic       txOrC;
      logic       chanAOrB;
      logic       chanBOrA;
      logic       strobeSel;
      logic       fieldCoverage;
      logic [1:0] spare;
   } scr_s;

   typedef struct packed {
      slot_mode_e mode;
      logic [5:0] slot;
   } entry_s;

   typedef struct packed {
      psr_s                         clock_phase_shift;
      scr_s                         signaling_strobe_config;
      entry_s [NUM_ENTRIES-1:0]     ent;
   } snapshot_s;

   typedef struct packed {
      logic       hit;
      logic       cpuXfer;
      logic       highway;
      logic [2:0] chan;
   } slot_hit_s;

endpackage : pcm_slot_switch_pkg

// file: hdl/pcm_slot_switch_strobe.sv
// Slot switching and signaling strobe logic of a PCM highway controller.
// Assumes a byte-wide processor register port on clk and a free-running highway bit clock
// with a frame sync pulse on linkClk; the two clocks are unrelated.
`timescale 1ns/1ps
module pcm_slot_switch_strobe (
   // System clock and reset.
   input  wire logic                           clk,
   input  wire logic                           sys_rst,
   // Processor register port.
   input  wire logic                           regWrEn,
   input  wire logic                           regRdEn,
   input  wire logic [4:0]                     regAddr,
   input  wire logic [7:0]                     regWrData,
   output      logic [7:0]                     regRdData,
   // Highway side.
   input  wire logic                           linkClk,
   input  wire logic                           frame_sync_pulse,
   output      pcm_slot_switch_pkg::slot_hit_s txSlotHit,
   output      pcm_slot_switch_pkg::slot_hit_s rxSlotHit,
   output      logic                           signaling_strobe_out
);

   // ****************************************
   // Processor side registers
   // ****************************************
   pcm_slot_switch_pkg::psr_s                              clock_phase_shift_q;
   pcm_slot_switch_pkg::scr_s                              signaling_strobe_config_q;
   pcm_slot_switch_pkg::entry_s [pcm_slot_switch_pkg::NUM_ENTRIES-1:0] slot_assign_entry_q;
   logic                                                   dirty_q;
   logic [7:0]                                             regRdData_q;
   logic                                                   entrySel;
   logic [3:0]                                             entryIdx;
   logic                                                   handOffPending;

   assign entrySel = (regAddr[4] == pcm_slot_switch_pkg::REG_ENTRY_BASE[4]);
   assign entryIdx = regAddr[3:0];

   // Register writes; a write marks the configuration for hand-off to the link side.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         clock_phase_shift_q       <= pcm_slot_switch_pkg::PSR_RESET;
         signaling_strobe_config_q <= pcm_slot_switch_pkg::SCR_RESET;
         for (int i = 0; i < pcm_slot_switch_pkg::NUM_ENTRIES; i++) begin
            slot_assign_entry_q[i] <= pcm_slot_switch_pkg::ENTRY_RESET;
         end
      end else if (regWrEn) begin
         if (regAddr == pcm_slot_switch_pkg::REG_PSR) begin
            clock_phase_shift_q <= {2'b00, regWrData[5:0]};
         end
         if (regAddr == pcm_slot_switch_pkg::REG_SCR) begin
            signaling_strobe_config_q <= regWrData;
         end
         if (entrySel) begin
            slot_assign_entry_q[entryIdx] <= regWrData;
         end
      end
   end

   // Read data is registered; the shift register is write-only and reads zero.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         regRdData_q <= 8'h00;
      end else if (regRdEn) begin
         if (regAddr == pcm_slot_switch_pkg::REG_SCR) begin
            regRdData_q <= signaling_strobe_config_q;
         end else if (regAddr == pcm_slot_switch_pkg::REG_STATUS) begin
            regRdData_q <= {7'h00, handOffPending};
         end else if (entrySel) begin
            regRdData_q <= slot_assign_entry_q[entryIdx];
         end else begin
            regRdData_q <= 8'h00;
         end
      end
   end
   assign regRdData = regRdData_q;

   // ****************************************
   // Configuration hand-off to the link clock
   // ****************************************
   // The whole configuration moves as one snapshot under a toggle handshake, so the link
   // side never sees a half-updated entry table; the cost is two wide copies, the snapshot and the link-side shadow.
   pcm_slot_switch_pkg::hand_state_e handState_q;
   pcm_slot_switch_pkg::snapshot_s   snap_q;
   logic                             req_q;
   logic                             ackMeta_q;
   logic                             ackSync_q;

   // Pending covers a snapshot still in flight, not only writes not yet sent.
   assign handOffPending = dirty_q || (handState_q == pcm_slot_switch_pkg::HAND_BUSY);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dirty_q <= 1'b1;
      end else if (regWrEn && (regAddr != pcm_slot_switch_pkg::REG_STATUS)) begin
         dirty_q <= 1'b1;
      end else if (handState_q == pcm_slot_switch_pkg::HAND_IDLE) begin
         dirty_q <= 1'b0;
      end
   end

   // Handshake sender: snapshot taken at launch, held until acknowledged.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         handState_q <= pcm_slot_switch_pkg::HAND_IDLE;
         req_q       <= 1'b0;
         snap_q      <= '0;
      end else begin
         unique case (handState_q)
            pcm_slot_switch_pkg::HAND_IDLE: begin
               if (dirty_q) begin
                  snap_q      <= {clock_phase_shift_q, signaling_strobe_config_q,
                                  slot_assign_entry_q};
                  req_q       <= ~req_q;
                  handState_q <= pcm_slot_switch_pkg::HAND_BUSY;
               end
            end
            pcm_slot_switch_pkg::HAND_BUSY: begin
               if (ackSync_q == req_q) begin
                  handState_q <= pcm_slot_switch_pkg::HAND_IDLE;
               end
            end
         endcase
      end
   end

   // Acknowledge synchroniser back into clk.
   logic ackLink_q;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ackMeta_q <= 1'b0;
         ackSync_q <= 1'b0;
      end else begin
         ackMeta_q <= ackLink_q;
         ackSync_q <= ackMeta_q;
      end
   end

   // ****************************************
   // Link clock domain
   // ****************************************
   logic                           linkRstMeta_q;
   logic                           linkRst_q;
   logic                           reqMeta_q;
   logic                           reqSync_q;
   logic                           reqSeen_q;
   logic                           syncMeta_q;
   logic                           syncSync_q;
   logic                           syncPrev_q;
   pcm_slot_switch_pkg::snapshot_s shadow_q;
   logic [7:0]                     bitCnt_q;
   logic                           strobe_q;
   pcm_slot_switch_pkg::slot_hit_s txHit_q;
   pcm_slot_switch_pkg::slot_hit_s rxHit_q;

   // Reset and request synchronisers; only the second stages are used by logic.
   always_ff @(posedge linkClk) begin
      linkRstMeta_q <= sys_rst;
      linkRst_q     <= linkRstMeta_q;
   end

   always_ff @(posedge linkClk) begin
      if (linkRst_q) begin
         reqMeta_q  <= 1'b0;
         reqSync_q  <= 1'b0;
         syncMeta_q <= 1'b0;
         syncSync_q <= 1'b0;
         syncPrev_q <= 1'b0;
      end else begin
         reqMeta_q  <= req_q;
         reqSync_q  <= reqMeta_q;
         syncMeta_q <= frame_sync_pulse;
         syncSync_q <= syncMeta_q;
         syncPrev_q <= syncSync_q;
      end
   end

   // Shadow load; the snapshot has been stable for two link edges before it is sampled.
   always_ff @(posedge linkClk) begin
      if (linkRst_q) begin
         reqSeen_q <= 1'b0;
         ackLink_q <= 1'b0;
         shadow_q  <= '0;
      end else if (reqSync_q != reqSeen_q) begin
         reqSeen_q <= reqSync_q;
         ackLink_q <= reqSync_q;
         shadow_q  <= snap_q;
      end
   end

   // Frame bit counter, restarted by the frame sync edge less the synchroniser delay.
   logic frameEdge;
   assign frameEdge = syncSync_q && !syncPrev_q;

   always_ff @(posedge linkClk) begin
      if (linkRst_q) begin
         bitCnt_q <= 8'h00;
      end else if (frameEdge) begin
         bitCnt_q <= pcm_slot_switch_pkg::SYNC_LATENCY;
      end else begin
         bitCnt_q <= bitCnt_q + 8'h01;
      end
   end

   // Shifted highway bit counts; one pair serves both highways.
   function automatic logic [7:0] shifted_count(input logic [7:0] cnt, input logic [2:0] code);
      logic [2:0] shiftAmt;
      shiftAmt = code + pcm_slot_switch_pkg::SHIFT_BIAS;
      return cnt - {5'h00, shiftAmt};
   endfunction : shifted_count

   // Searches one half of the entry table for the current slot; lowest channel wins.
   function automatic pcm_slot_switch_pkg::slot_hit_s find_slot(
      input pcm_slot_switch_pkg::snapshot_s s, input logic rxHalf, input logic [7:0] cnt);
      pcm_slot_switch_pkg::slot_hit_s r;
      pcm_slot_switch_pkg::entry_s    e;
      r = '0;
      e = '0;
      for (int c = pcm_slot_switch_pkg::NUM_CHAN - 1; c >= 0; c--) begin
         e = s.ent[{rxHalf, 3'(c)}];
         if ((e.mode != pcm_slot_switch_pkg::MODE_NONE) && (e.slot == {1'b0, cnt[7:3]})) begin
            r.hit     = 1'b1;
            r.cpuXfer = (e.mode == pcm_slot_switch_pkg::MODE_CPU);
            r.highway = (e.mode == pcm_slot_switch_pkg::MODE_HW1);
            r.chan    = 3'(c);
         end
      end
      return r;
   endfunction : find_slot

   logic [7:0] txCnt;
   logic [7:0] rxCnt;
   assign txCnt = shifted_count(bitCnt_q, shadow_q.clock_phase_shift.txShift);
   assign rxCnt = shifted_count(bitCnt_q, shadow_q.clock_phase_shift.rxShift);

   // Slot switching outputs, registered once.
   always_ff @(posedge linkClk) begin
      if (linkRst_q) begin
         txHit_q <= '0;
         rxHit_q <= '0;
      end else begin
         txHit_q <= find_slot(shadow_q, 1'b0, txCnt);
         rxHit_q <= find_slot(shadow_q, 1'b1, rxCnt);
      end
   end
   assign txSlotHit = txHit_q;
   assign rxSlotHit = rxHit_q;

   // ****************************************
   // Signaling strobe
   // ****************************************
   logic [2:0] subByte;
   logic [2:0] sigBit;
   logic       inSig;
   logic       isTx;
   logic       isChanA;
   logic       strobeNext;
   assign subByte = bitCnt_q[5:3];
   assign sigBit  = 3'h7 - bitCnt_q[2:0];
   assign isTx    = !subByte[2];
   assign isChanA = !subByte[0];
   assign inSig   = (bitCnt_q[7:6] == 2'b00) && (subByte[1] == 1'b1);

   // Link-side copy of the strobe configuration.
   pcm_slot_switch_pkg::scr_s signaling_strobe_config_q_link;
   assign signaling_strobe_config_q_link = shadow_q.signaling_strobe_config;

   // Strobe decode; the external driver turns on from this, so every unlisted bit stays low.
   always_comb begin
      logic [2:0] ofs;
      logic [3:0] pos;
      logic       fixed;
      logic       posHit;
      ofs        = '0;
      pos        = '0;
      fixed      = 1'b0;
      posHit     = 1'b0;
      strobeNext = 1'b0;
      // Position A is bit 4 and sits lowest in the byte; D is bit 7 and sits highest.
      pos = signaling_strobe_config_q_link[7:4];
      if (!inSig) begin
         strobeNext = 1'b0;
      end else if (!signaling_strobe_config_q_link.strobeSel) begin
         strobeNext = (isTx ? signaling_strobe_config_q_link.txOrC
                            : signaling_strobe_config_q_link.rxOrD) &&
                      (isChanA ? signaling_strobe_config_q_link.chanAOrB
                               : signaling_strobe_config_q_link.chanBOrA);
      end else begin
         if (signaling_strobe_config_q_link.fieldCoverage) begin
            ofs   = pcm_slot_switch_pkg::POS_OFS_FULL;
            fixed = (sigBit == 3'h0);
         end else begin
            ofs   = isTx ? pcm_slot_switch_pkg::POS_OFS_TX : pcm_slot_switch_pkg::POS_OFS_RX;
            fixed = sigBit <= (isTx ? pcm_slot_switch_pkg::FIX_TX_TOP
                                    : pcm_slot_switch_pkg::FIX_RX_TOP);
         end
         for (int p = 0; p < 4; p++) begin
            if (sigBit == ofs + 3'(p)) begin
               posHit = isTx ? !pos[p] : pos[p];
            end
         end
         strobeNext = fixed || posHit;
      end
   end

   // Strobe output flop; it trails the decoded bit by one link clock.
   always_ff @(posedge linkClk) begin
      if (linkRst_q) begin
         strobe_q <= 1'b0;
      end else begin
         strobe_q <= strobeNext;
      end
   end
   assign signaling_strobe_out = strobe_q;

   // ****************************************
   // Assertions
   // ****************************************
   logic [4:0] waitCnt_q;
   always_ff @(posedge clk) begin
      if (sys_rst || handState_q == pcm_slot_switch_pkg::HAND_IDLE) begin
         waitCnt_q <= 5'h00;
      end else if (waitCnt_q != 5'h1F) begin
         waitCnt_q <= waitCnt_q + 5'h01;
      end
   end

   sequence s_scr_write;
      regWrEn && (regAddr == pcm_slot_switch_pkg::REG_SCR);
   endsequence
   sequence s_scr_read;
      regRdEn && !regWrEn && (regAddr == pcm_slot_switch_pkg::REG_SCR);
   endsequence

   a_psr_reads_zero: assert property (@(posedge clk) disable iff (sys_rst)
      regRdEn && regAddr == pcm_slot_switch_pkg::REG_PSR |=> regRdData == 8'h00)
      else $error("shift register read returned nonzero");
   a_reset_clears_cfg: assert property (@(posedge clk)
      $past(sys_rst) |-> clock_phase_shift_q == 8'h00 && signaling_strobe_config_q == 8'h00)
      else $error("configuration not zero after reset");
   a_scr_read_back: assert property (@(posedge clk) disable iff (sys_rst)
      (s_scr_write ##1 !regWrEn ##1 s_scr_read) |=> regRdData == $past(regWrData, 3))
      else $error("strobe configuration read back differs");
   a_handoff_bounded: assert property (@(posedge clk) disable iff (sys_rst)
      waitCnt_q <= 5'(pcm_slot_switch_pkg::HANDOFF_LIMIT))
      else $error("configuration hand-off took too long");
   a_strobe_in_sig: assert property (@(posedge linkClk) disable iff (linkRst_q)
      strobe_q |-> $past(inSig))
      else $error("strobe high outside a signaling byte");
   a_strobe_no_dir: assert property (@(posedge linkClk) disable iff (linkRst_q)
      !$past(shadow_q.signaling_strobe_config.strobeSel) && !$past(shadow_q.signaling_strobe_config.rxOrD) && !$past(shadow_q.signaling_strobe_config.txOrC)
      |-> !strobe_q)
      else $error("strobe high with no direction enabled");
   a_bit0_high: assert property (@(posedge linkClk) disable iff (linkRst_q)
      $past(inSig && sigBit == 3'h0 && shadow_q.signaling_strobe_config.strobeSel && shadow_q.signaling_strobe_config.fieldCoverage)
      |-> strobe_q)
      else $error("strobe low at signaling bit zero");
   a_tx_pos_low: assert property (@(posedge linkClk) disable iff (linkRst_q)
      $past(inSig && isTx && shadow_q.signaling_strobe_config.strobeSel && shadow_q.signaling_strobe_config.fieldCoverage &&
            sigBit == 3'h1 && shadow_q.signaling_strobe_config.chanBOrA) |-> !strobe_q)
      else $error("transmit strobe high at a selected position");
   a_frame_restart: assert property (@(posedge linkClk) disable iff (linkRst_q)
      frameEdge |=> bitCnt_q == pcm_slot_switch_pkg::SYNC_LATENCY ##1
                    bitCnt_q == pcm_slot_switch_pkg::SYNC_LATENCY + 8'h01)
      else $error("frame counter did not restart on sync");

endmodule : pcm_slot_switch_strobe

// file: sim/pcm_highway_model.sv
// Highway stand-in: free-running bit clock and one frame sync pulse per 256 bits.
// Assumes the block samples frame sync on the rising bit clock edge.
`timescale 1ns/1ps
module pcm_highway_model (
   // Highway timing.
   output logic       linkClk,
   output logic       frame_sync_pulse,
   output logic [7:0] bitPos
);
   // ****************************************
   // Bit clock and frame
   // ****************************************
   // The odd start offset keeps the bit clock unrelated in phase to the system clock.
   initial begin
      linkClk = 1'b0;
      bitPos = 8'h00;
      frame_sync_pulse = 1'b0;
      #7;
      forever #16 linkClk = ~linkClk;
   end

   // Position counts from the edge that first samples the sync pulse.
   always @(posedge linkClk) bitPos <= bitPos + 8'h01;

   // Sync rises half a bit before position 0 and lasts one bit.
   always @(negedge linkClk) frame_sync_pulse <= (bitPos == 8'hff);
endmodule : pcm_highway_model

// file: sim/pcm_slot_switch_strobe_tb_top.sv
// Self-checking bench: register port tasks, per-bit strobe and slot hit model.
// Assumes the highway model's bit position lags the block's frame count by one bit.
`timescale 1ns/1ps
module pcm_slot_switch_strobe_tb_top;
   logic                           clk, sys_rst, regWrEn, regRdEn, on;
   logic                           linkClk, frame_sync_pulse, signaling_strobe_out;
   logic [4:0]                     regAddr;
   logic [7:0]                     regWrData, regRdData, bitPos, signaling_strobe_config, clock_phase_shift, cnt;
   pcm_slot_switch_pkg::slot_hit_s txSlotHit, rxSlotHit;
   pcm_slot_switch_pkg::entry_s    txEnt, rxEnt;
   int                             failures = 0;
   int                             checksDone = 0;

   pcm_highway_model u_pcm_highway_model (.linkClk(linkClk),
      .frame_sync_pulse(frame_sync_pulse), .bitPos(bitPos));
   pcm_slot_switch_strobe u_pcm_slot_switch_strobe (.clk(clk), .sys_rst(sys_rst),
      .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
      .regRdData(regRdData), .linkClk(linkClk), .frame_sync_pulse(frame_sync_pulse),
      .txSlotHit(txSlotHit), .rxSlotHit(rxSlotHit),
      .signaling_strobe_out(signaling_strobe_out));

   // ****************************************
   // Reference model and tasks
   // ****************************************
   always #20 clk = ~clk;

   // Strobe level for one count; only signaling bytes of the first 64 bits qualify.
   function automatic logic expStrobe(logic [7:0] s, logic [7:0] c);
      logic [2:0] b;
      logic [3:0] p;
      logic       rx;
      b = 3'h7 - c[2:0];
      p = s[7:4];
      rx = c[5];
      if (c[7:6] != 2'b00 || !c[4]) return 1'b0;
      if (!s[3]) return (rx ? s[7] : s[6]) & (c[3] ? s[4] : s[5]);
      if (s[2]) return b == 3'h0 || (b <= 3'h4 && p[b - 3'h1] == rx);
      if (rx) return b <= 3'h1 || (b <= 3'h5 && p[b - 3'h2]);
      return b <= 3'h2 || (b <= 3'h6 && !p[b - 3'h3]);
   endfunction : expStrobe

   function automatic pcm_slot_switch_pkg::slot_hit_s expHit(logic [2:0] code,
      logic [7:0] c, pcm_slot_switch_pkg::entry_s e, logic [2:0] ch);
      logic [7:0] v;
      v = (c - {5'h00, code + 3'h2}) >> 3;
      expHit = '0;
      if (e.mode != pcm_slot_switch_pkg::MODE_NONE && e.slot == v[5:0]) begin
         expHit = {1'b1, e.mode == pcm_slot_switch_pkg::MODE_CPU,
                   e.mode == pcm_slot_switch_pkg::MODE_HW1, ch};
      end
   endfunction : expHit

   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      checksDone++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check8

   // Fields other than the hit flag mean nothing while no slot matches.
   task automatic cmpHit(input string what, input pcm_slot_switch_pkg::slot_hit_s e,
      input pcm_slot_switch_pkg::slot_hit_s g);
      check8(what, e.hit ? {2'b00, e} : 8'h00, e.hit ? {2'b00, g} : {7'h00, g.hit});
   endtask : cmpHit

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      regWrEn <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWrEn <= 1'b0;
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic [7:0] exp, input string what);
      @(posedge clk);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRdEn <= 1'b0;
      #1;
      check8(what, exp, regRdData);
   endtask : rd

   // Polls the pending flag; the hand-off must finish within its bound.
   task automatic settle();
      for (int n = 0; n < 12; n++) begin
         @(posedge clk);
         regRdEn <= 1'b1;
         regAddr <= pcm_slot_switch_pkg::REG_STATUS;
         @(posedge clk);
         regRdEn <= 1'b0;
         #1;
         if (regRdData[0] === 1'b0) break;
      end
      check8("handoff", 8'h00, {7'h00, regRdData[0]});
   endtask : settle

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checksDone, failures);
      if (failures == 0 && checksDone > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop

   // Per-bit comparison; the model lags the block's count by one bit and each output lags
   // its count by one bit, so the outputs seen now belong to the model position.
   always @(posedge linkClk) begin
      if (on) begin
         #1;
         cnt = bitPos;
         check8("strobe", {7'h00, expStrobe(signaling_strobe_config, cnt)}, {7'h00, signaling_strobe_out});
         cmpHit("txHit", expHit(clock_phase_shift[5:3], cnt, txEnt, 3'h5), txSlotHit);
         cmpHit("rxHit", expHit(clock_phase_shift[2:0], cnt, rxEnt, 3'h2), rxSlotHit);
      end
   end

   initial begin
      #1_000_000;
      failures++;
      report_and_stop();
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      logic [3:0] fillTab [5];
      fillTab = '{4'h0, 4'h1, 4'h3, 4'h7, 4'hf};
      {clk, sys_rst, regWrEn, regRdEn, on, regAddr, regWrData} = {5'b01000, 5'h00, 8'h00};
      void'($urandom(32'h1861_fb68));
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      rd(pcm_slot_switch_pkg::REG_SCR, 8'h00, "scrReset");
      rd(pcm_slot_switch_pkg::REG_PSR, 8'h00, "psrRead");
      rd(5'h15, pcm_slot_switch_pkg::ENTRY_RESET, "entryReset");
      wr(5'h05, 8'h5a);
      rd(5'h05, 8'h00, "unmapped");
      wr(pcm_slot_switch_pkg::REG_SCR, 8'ha4);
      rd(pcm_slot_switch_pkg::REG_SCR, 8'ha4, "scrBack");
      settle();
      $display("test registers done");
      for (int i = 0; i < 12; i++) begin
         // Transmit positions are a contiguous fill so the two drivers never overlap.
         signaling_strobe_config = i < 4 ? {(i == 0) ? 4'h0 : 4'($urandom), 4'h0}
                     : {fillTab[$urandom % 5], 1'b1, i[0], 2'b00};
         clock_phase_shift = {2'b11, 3'(i), 3'(7 - i)};
         // Written slots are random; the wanted slot is the written one plus the shift offset.
         txEnt = {2'(i), 6'($urandom % 32)};
         rxEnt = {2'(i + 1), 6'($urandom % 32)};
         wr(pcm_slot_switch_pkg::REG_SCR, signaling_strobe_config);
         wr(pcm_slot_switch_pkg::REG_PSR, clock_phase_shift);
         wr(5'h15, txEnt);
         wr(5'h1a, rxEnt);
         rd(5'h15, txEnt, "txEntry");
         rd(pcm_slot_switch_pkg::REG_PSR, 8'h00, "psrHidden");
         settle();
         repeat (300) @(posedge linkClk);
         @(negedge linkClk);
         on = 1'b1;
         repeat (256) @(posedge linkClk);
         @(negedge linkClk);
         on = 1'b0;
         $display("test %0d scr %h psr %h done", i, signaling_strobe_config, clock_phase_shift);
      end
      report_and_stop();
   end
endmodule : pcm_slot_switch_strobe_tb_top
